// file: hw/pmc_pkg.sv
// Package for the operating-mode controller: modes, register map,
// field positions, reset values and timing constants.
// Assumes a single 25 MHz system clock and 8-bit register data.
`default_nettype none

package pmc_pkg;

  // Operating modes and internal way-points
  typedef enum logic [3:0] {
    PM_RESET, PM_HIGH, PM_MED, PM_SUB, PM_SLEEP, PM_STANDBY,
    PM_WATCH, PM_SUBSLEEP, PM_SETTLE, PM_DT_WAY, PM_DT_EXC
  } pmc_mode_e;

  // Register indices
  localparam logic [2:0] OFS_CTRL_ONE  = 3'h0;
  localparam logic [2:0] OFS_CTRL_TWO  = 3'h1;
  localparam logic [2:0] OFS_WATCH_TMR = 3'h2;
  localparam logic [2:0] OFS_WAKE_EN0  = 3'h3;
  localparam logic [2:0] OFS_WAKE_EN1  = 3'h4;
  localparam logic [2:0] OFS_STATUS    = 3'h5;

  // Field positions
  localparam int STBY_POS   = 7;
  localparam int STS_LSB    = 4;
  localparam int LOWSPD_POS = 3;
  localparam int MA_LSB     = 0;
  localparam int DIRECT_POS = 3;
  localparam int MEDSEL_POS = 2;
  localparam int SA_LSB     = 0;
  localparam int TMCS_POS   = 3;
  localparam int DTEN_POS   = 7;
  localparam int LOCK_POS   = 4;

  // Reset values
  localparam logic [7:0] CTRL_ONE_RST  = 8'h00;
  localparam logic [7:0] CTRL_TWO_RST  = 8'h00;
  localparam logic [7:0] WATCH_TMR_RST = 8'h00;
  localparam logic [7:0] WAKE_EN_RST   = 8'h00;

  // Wake vector: timer A,C,F,G, async counter, serial 1,2, ext 0..4, pins
  localparam int          WAKE_W       = 13;
  localparam logic [12:0] WAKE_SLEEP   = 13'h1FFF;
  localparam logic [12:0] WAKE_SUBSLP  = 13'h1FFF;
  localparam logic [12:0] WAKE_WATCH   = 13'h108D;
  localparam logic [12:0] WAKE_STANDBY = 13'h1180;

  // Direct transfer timing in CPU states
  localparam int SLEEP_STATES = 2;
  localparam int INTERNAL_STATES = 1;
  localparam int EXC_STATES = 14;
  localparam logic [17:0] WAY_LOAD = 18'(SLEEP_STATES + INTERNAL_STATES - 1);
  localparam logic [17:0] EXC_LOAD = 18'(EXC_STATES - 1);

  // Settling waits in system clock states
  localparam int STS_BASE_STATES = 8192;
  localparam int STS_SHORT2 = 2;
  localparam int STS_SHORT8 = 8;
  localparam int STS_SHORT16 = 16;

  // Medium divider starts at /8, subactive at watch /2
  localparam logic [2:0] MED_SHIFT_BASE = 3'h3;

endpackage

`default_nettype wire

// file: hw/pmc_sync.sv
// Two-stage synchroniser for one level from outside the clock domain.
// Assumes the input may change at any time.
`default_nettype none

module pmc_sync
  import pmc_pkg::*;
#(
  parameter logic RST_VAL = 1'b0
)
(
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic async_in,
  output var  logic sync_out
);

  logic meta_reg;

  // First stage feeds only the second
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      meta_reg <= RST_VAL;
      sync_out <= RST_VAL;
    end
    else
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule

`default_nettype wire

// file: hw/pmc_clk_div.sv
// CPU clock tick generator: divides a base tick by a power of two.
// Assumes base_tick is a one-cycle pulse on ref_clk.
`default_nettype none

module pmc_clk_div
  import pmc_pkg::*;
#(
  parameter int CNT_W = 7
)
(
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic             run,
  input  wire logic             base_tick,
  input  wire logic [2:0]       shift,
  output var  logic             tick
);

  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] last;
  logic             wrap;

  // Terminal count for the chosen ratio
  assign last = CNT_W'((1 << shift) - 1);
  assign wrap = base_tick && (cnt_reg >= last);

  // Counter restarts whenever the clock is stopped
  always_ff @(posedge ref_clk)
  begin
    if (rst || !run)
    begin
      cnt_reg <= '0;
      tick    <= 1'b0;
    end
    else
    begin
      tick <= wrap;
      if (wrap)
        cnt_reg <= '0;
      else if (base_tick)
        cnt_reg <= cnt_reg + 1'b1;
    end
  end

endmodule

`default_nettype wire

// file: hw/pmc_mode_ctrl.sv
// Operating-mode controller: sleep decoding, wake-up, settling wait,
// direct transfer and CPU clock selection.
// Assumes sleep_exec, cpu_int_mask and wake_req come from logic on
// ref_clk; the init pin and the watch clock are asynchronous pins.
`default_nettype none

module pmc_mode_ctrl
  import pmc_pkg::*;
#(
  parameter int STS_BASE = STS_BASE_STATES
)
(
  input  wire logic                ref_clk,
  input  wire logic                rst,
  input  wire logic                chip_init_pin_n,
  input  wire logic                watch_clk_pin,
  input  wire logic [2:0]          reg_addr,
  input  wire logic [7:0]          reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output var  logic [7:0]          reg_rdata,
  input  wire logic                sleep_exec,
  input  wire logic                cpu_int_mask,
  input  wire logic [WAKE_W-1:0]   wake_req,
  output var  logic [3:0]          mode_code,
  output var  logic                cpu_tick,
  output var  logic                cpu_halted,
  output var  logic                dt_exc_start,
  output var  logic                dt_done
);

  // Register file
  logic [7:0]        system_control_one_reg;
  logic [7:0]        system_control_two_reg;
  logic [7:0]        watch_timer_control_reg;
  logic [7:0]        wake_en0_reg;
  logic [7:0]        wake_en1_reg;

  // Mode machine
  pmc_mode_e         state_reg;
  pmc_mode_e         state_next;
  pmc_mode_e         src_reg;
  pmc_mode_e         src_next;
  pmc_mode_e         tgt_reg;
  pmc_mode_e         tgt_next;
  pmc_mode_e         clk_mode;
  logic              settle_dt_reg;
  logic              settle_dt_next;
  logic              lock_reg;
  logic              lock_next;
  logic [17:0]       cnt_reg;
  logic [17:0]       cnt_next;
  logic              exc_start_next;
  logic              done_next;

  // Pin synchronisers and watch clock edge
  logic              init_sync;
  logic              watch_sync;
  logic              watch_dly_reg;
  logic              watch_edge;

  pmc_sync #(
    .RST_VAL (1'b1)
  ) u_init_sync (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .async_in (chip_init_pin_n),
    .sync_out (init_sync)
  );

  pmc_sync #(
    .RST_VAL (1'b0)
  ) u_watch_sync (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .async_in (watch_clk_pin),
    .sync_out (watch_sync)
  );

  // Delayed copy for rising-edge detection of the watch clock
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      watch_dly_reg <= 1'b0;
    else
      watch_dly_reg <= watch_sync;
  end

  assign watch_edge = watch_sync && !watch_dly_reg;

  // Control bit fields
  wire       software_standby_bit = system_control_one_reg[STBY_POS];
  wire       low_speed_on_bit     = system_control_one_reg[LOWSPD_POS];
  wire [2:0] settling_wait        = system_control_one_reg[STS_LSB +: 3];
  wire [1:0] medium_divider       = system_control_one_reg[MA_LSB +: 2];
  wire       direct_transfer_on_bit = system_control_two_reg[DIRECT_POS];
  wire       medium_speed_select_bit = system_control_two_reg[MEDSEL_POS];
  wire [1:0] subactive_divider    = system_control_two_reg[SA_LSB +: 2];
  wire       watch_timer_clock_select_bit = watch_timer_control_reg[TMCS_POS];
  wire [WAKE_W-1:0] wake_en       = {wake_en1_reg[4:0], wake_en0_reg};
  wire       dt_int_en            = wake_en1_reg[DTEN_POS];

  // Qualified wake requests
  wire [WAKE_W-1:0] wake_q = wake_req & wake_en
                           & {WAKE_W{!cpu_int_mask && !lock_reg}};

  // Mode classes
  wire in_act = (state_reg == PM_HIGH) || (state_reg == PM_MED);
  wire in_sub = (state_reg == PM_SUB);
  wire stby_on = software_standby_bit;
  wire low_on  = low_speed_on_bit;
  wire tmcs    = watch_timer_clock_select_bit;
  wire dir_on  = direct_transfer_on_bit;
  wire med_on  = medium_speed_select_bit;
  wire pmc_mode_e wake_act = med_on ? PM_MED : PM_HIGH;

  // Sleep decode from active modes
  wire act_watch   = stby_on && tmcs;
  wire act_standby = stby_on && !low_on && !tmcs;
  wire act_dt_sub  = act_watch && dir_on && low_on;
  wire act_dt_act  = !stby_on && !low_on && dir_on
                   && (med_on != (state_reg == PM_MED));

  // Sleep decode from subactive mode
  wire sub_watch   = stby_on && tmcs;
  wire sub_subslp  = !stby_on && low_on && tmcs;
  wire sub_dt      = sub_watch && !low_on && dir_on;

  // Direct transfer request, way-point and destination
  wire dt_req = in_act ? (act_dt_sub || act_dt_act) : (in_sub && sub_dt);
  wire dt_ok  = dt_int_en && !cpu_int_mask;
  wire pmc_mode_e dt_way = (in_act && act_dt_act) ? PM_SLEEP : PM_WATCH;
  wire pmc_mode_e dt_tgt = (in_act && act_dt_sub) ? PM_SUB : wake_act;

  // Ordinary sleep destination
  wire pmc_mode_e act_plain = act_watch ? PM_WATCH :
                              act_standby ? PM_STANDBY : PM_SLEEP;
  wire pmc_mode_e sub_plain = sub_watch ? PM_WATCH :
                              sub_subslp ? PM_SUBSLEEP : PM_SUB;
  wire pmc_mode_e plain_dst = in_sub ? sub_plain : act_plain;

  // Settling wait in system clock states
  logic [17:0] settle_load;
  always_comb
  begin
    case (settling_wait)
      3'h5:    settle_load = 18'(STS_SHORT2 - 1);
      3'h6:    settle_load = 18'(STS_SHORT8 - 1);
      3'h7:    settle_load = 18'(STS_SHORT16 - 1);
      default: settle_load = 18'((STS_BASE << settling_wait) - 1);
    endcase
  end

  wire cnt_zero = (cnt_reg == 18'h0);

  // Mode state machine
  always_comb
  begin
    state_next     = state_reg;
    src_next       = src_reg;
    tgt_next       = tgt_reg;
    settle_dt_next = settle_dt_reg;
    lock_next      = lock_reg;
    cnt_next       = cnt_reg;
    exc_start_next = 1'b0;
    done_next      = 1'b0;
    case (state_reg)
      PM_RESET:
      begin
        lock_next = 1'b0;
        if (init_sync)
          state_next = PM_MED;
      end
      PM_HIGH, PM_MED, PM_SUB:
      begin
        if (sleep_exec)
        begin
          src_next = state_reg;
          if (dt_req && dt_ok)
          begin
            state_next = PM_DT_WAY;
            tgt_next   = dt_tgt;
            cnt_next   = WAY_LOAD;
          end
          else if (dt_req)
          begin
            state_next = dt_way;
            lock_next  = cpu_int_mask;
          end
          else
            state_next = plain_dst;
        end
      end
      PM_SLEEP:
        if (|(wake_q & WAKE_SLEEP))
          state_next = wake_act;
      PM_STANDBY:
        if (|(wake_q & WAKE_STANDBY))
        begin
          state_next     = PM_SETTLE;
          tgt_next       = wake_act;
          settle_dt_next = 1'b0;
          cnt_next       = settle_load;
        end
      PM_WATCH:
        if (|(wake_q & WAKE_WATCH))
        begin
          if (low_on)
            state_next = PM_SUB;
          else
          begin
            state_next     = PM_SETTLE;
            tgt_next       = wake_act;
            settle_dt_next = 1'b0;
            cnt_next       = settle_load;
          end
        end
      PM_SUBSLEEP:
        if (|(wake_q & WAKE_SUBSLP))
          state_next = PM_SUB;
      PM_DT_WAY:
        if (cpu_tick)
        begin
          if (!cnt_zero)
            cnt_next = cnt_reg - 18'h1;
          else if (src_reg == PM_SUB)
          begin
            state_next     = PM_SETTLE;
            settle_dt_next = 1'b1;
            cnt_next       = settle_load;
          end
          else
          begin
            state_next     = PM_DT_EXC;
            exc_start_next = 1'b1;
            cnt_next       = EXC_LOAD;
          end
        end
      PM_SETTLE:
        if (!cnt_zero)
          cnt_next = cnt_reg - 18'h1;
        else if (settle_dt_reg)
        begin
          state_next     = PM_DT_EXC;
          exc_start_next = 1'b1;
          cnt_next       = EXC_LOAD;
        end
        else
          state_next = tgt_reg;
      PM_DT_EXC:
        // Skip the tick launched by the old clock on entry
        if (cpu_tick && !dt_exc_start)
        begin
          if (!cnt_zero)
            cnt_next = cnt_reg - 18'h1;
          else
          begin
            state_next = tgt_reg;
            done_next  = 1'b1;
          end
        end
      default:
        state_next = PM_RESET;
    endcase
    if (!init_sync)
      state_next = PM_RESET;
  end

  // Mode state registers
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      state_reg     <= PM_RESET;
      src_reg       <= PM_MED;
      tgt_reg       <= PM_MED;
      settle_dt_reg <= 1'b0;
      lock_reg      <= 1'b0;
      cnt_reg       <= 18'h0;
      dt_exc_start  <= 1'b0;
      dt_done       <= 1'b0;
    end
    else
    begin
      state_reg     <= state_next;
      src_reg       <= src_next;
      tgt_reg       <= tgt_next;
      settle_dt_reg <= settle_dt_next;
      lock_reg      <= lock_next;
      cnt_reg       <= cnt_next;
      dt_exc_start  <= exc_start_next;
      dt_done       <= done_next;
    end
  end

  // Clock follows the old mode on the way out, the new one in exception
  assign clk_mode = (state_reg == PM_DT_WAY) ? src_reg :
                    (state_reg == PM_DT_EXC) ? tgt_reg : state_reg;

  wire       clk_run   = (clk_mode == PM_HIGH) || (clk_mode == PM_MED)
                      || (clk_mode == PM_SUB);
  wire       base_tick = (clk_mode == PM_SUB) ? watch_edge : 1'b1;
  wire [2:0] sub_shift = (subactive_divider == 2'h0) ? 3'h1 :
                         (subactive_divider == 2'h1) ? 3'h2 : 3'h3;
  wire [2:0] med_shift = MED_SHIFT_BASE + {1'b0, medium_divider};
  wire [2:0] div_shift = (clk_mode == PM_SUB) ? sub_shift :
                         (clk_mode == PM_MED) ? med_shift : 3'h0;

  pmc_clk_div #(
    .CNT_W (7)
  ) u_cpu_div (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .run       (clk_run),
    .base_tick (base_tick),
    .shift     (div_shift),
    .tick      (cpu_tick)
  );

  // Status outputs
  assign mode_code  = state_reg;
  assign cpu_halted = !clk_run;

  // Register writes
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      system_control_one_reg  <= CTRL_ONE_RST;
      system_control_two_reg  <= CTRL_TWO_RST;
      watch_timer_control_reg <= WATCH_TMR_RST;
      wake_en0_reg            <= WAKE_EN_RST;
      wake_en1_reg            <= WAKE_EN_RST;
    end
    else if (reg_wr)
    begin
      if (reg_addr == OFS_CTRL_ONE)
        system_control_one_reg <= reg_wdata;
      else if (reg_addr == OFS_CTRL_TWO)
        system_control_two_reg <= reg_wdata;
      else if (reg_addr == OFS_WATCH_TMR)
        watch_timer_control_reg <= reg_wdata;
      else if (reg_addr == OFS_WAKE_EN0)
        wake_en0_reg <= reg_wdata;
      else if (reg_addr == OFS_WAKE_EN1)
        wake_en1_reg <= reg_wdata;
    end
  end

  // Read selection; unmapped addresses read zero
  wire [7:0] status_val = {3'h0, lock_reg, mode_code};
  wire [7:0] rd_val =
    (reg_addr == OFS_CTRL_ONE)  ? system_control_one_reg :
    (reg_addr == OFS_CTRL_TWO)  ? system_control_two_reg :
    (reg_addr == OFS_WATCH_TMR) ? watch_timer_control_reg :
    (reg_addr == OFS_WAKE_EN0)  ? wake_en0_reg :
    (reg_addr == OFS_WAKE_EN1)  ? wake_en1_reg :
    (reg_addr == OFS_STATUS)    ? status_val : 8'h00;

  // Read data stands for one cycle only
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      reg_rdata <= 8'h00;
    else
      reg_rdata <= reg_rd ? rd_val : 8'h00;
  end

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence dt_launch;
    in_act && sleep_exec && dt_req && dt_ok && init_sync;
  endsequence

  sequence dt_walk;
    ##1 (state_reg == PM_DT_WAY) ##1 (state_reg == PM_DT_WAY);
  endsequence

  init_pin_a: assert property (!init_sync |=> state_reg == PM_RESET)
    else $error("init pin low did not reset mode");
  reset_exit_a: assert property ((state_reg == PM_RESET) && init_sync
    |=> state_reg == PM_MED)
    else $error("reset exit not into medium speed");
  masked_wake_a: assert property (cpu_int_mask && init_sync
    && ((state_reg == PM_SLEEP) || (state_reg == PM_STANDBY)
    || (state_reg == PM_WATCH) || (state_reg == PM_SUBSLEEP))
    |=> state_reg == $past(state_reg))
    else $error("masked interrupt woke a sleep mode");
  subsleep_wake_a: assert property ((state_reg == PM_SUBSLEEP)
    && (|wake_q) && init_sync |=> state_reg == PM_SUB)
    else $error("subsleep wake not into subactive");
  watch_low_a: assert property ((state_reg == PM_WATCH) && low_on
    && (|(wake_q & WAKE_WATCH)) && init_sync |=> state_reg == PM_SUB)
    else $error("watch wake with low speed not into subactive");
  standby_entry_a: assert property (in_act && sleep_exec && stby_on
    && !low_on && !tmcs && init_sync |=> state_reg == PM_STANDBY)
    else $error("standby not entered");
  subsleep_entry_a: assert property (in_sub && sleep_exec && sub_subslp
    && init_sync |=> state_reg == PM_SUBSLEEP)
    else $error("subsleep not entered");
  lock_hold_a: assert property (lock_reg && init_sync
    && ((state_reg == PM_SLEEP) || (state_reg == PM_WATCH))
    |=> state_reg == $past(state_reg))
    else $error("locked way-point was released");
  dt_path_a: assert property (dt_launch |-> dt_walk)
    else $error("direct transfer did not enter way-point");
  dt_refused_a: assert property (in_act && sleep_exec && dt_req
    && !dt_ok && init_sync |=> state_reg == $past(dt_way))
    else $error("refused direct transfer left wrong mode");
  exc_start_a: assert property (dt_exc_start
    |-> state_reg == PM_DT_EXC && cnt_reg == EXC_LOAD)
    else $error("exception start without exception count");

endmodule

`default_nettype wire

// file: sim/power_mode_controller_bench.sv
// Bench for the operating-mode controller: register access, sleep decode,
// wake-up, settling, direct transfer, CPU tick rates and the init pin.
// Assumes pmc_pkg and pmc_mode_ctrl are compiled before this file.
`default_nettype none

module power_mode_controller_bench
  import pmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int STS_SIM = 4;

  logic              ref_clk         = 1'b0;
  logic              rst             = 1'b1;
  logic              chip_init_pin_n = 1'b1;
  logic              watch_clk_pin   = 1'b0;
  logic [2:0]        reg_addr        = 3'h0;
  logic [7:0]        reg_wdata       = 8'h00;
  logic              reg_wr          = 1'b0;
  logic              reg_rd          = 1'b0;
  logic [7:0]        reg_rdata;
  logic              sleep_exec      = 1'b0;
  logic              cpu_int_mask    = 1'b0;
  logic [WAKE_W-1:0] wake_req        = '0;
  logic [3:0]        mode_code;
  logic              cpu_tick;
  logic              cpu_halted;
  logic              dt_exc_start;
  logic              dt_done;
  int                n_mismatch      = 0;
  int                n_compared      = 0;
  int                cyc             = 0;
  int                seed            = 32'h9B3A;
  logic [7:0]        rv;
  int                i;

  // System clock and a watch clock of unrelated phase
  always #20 ref_clk = ~ref_clk;
  always #70 watch_clk_pin = ~watch_clk_pin;

  pmc_mode_ctrl #(.STS_BASE(STS_SIM)) i_pmc_mode_ctrl
  (
    .ref_clk, .rst, .chip_init_pin_n, .watch_clk_pin, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .sleep_exec, .cpu_int_mask, .wake_req,
    .mode_code, .cpu_tick, .cpu_halted, .dt_exc_start, .dt_done
  );

  // Verdict and end of run
  task automatic tally_and_finish;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Cycle ceiling against hangs
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      n_mismatch++;
      tally_and_finish;
    end
  end

  // Compare tasks: register byte, mode, cycle count within a tolerance
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chkm(input logic [3:0] got, input logic [3:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chkn(input int got, input int exp, input int tol);
    n_compared++;
    if (got < exp - tol || got > exp + tol)
    begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Expected settling states for a field value
  function automatic int sts_states(input int f);
    if (f < 5)
      return STS_SIM << f;
    return (f == 5) ? 2 : (f == 6) ? 8 : 16;
  endfunction

  // Register bus cycles
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    @(negedge ref_clk);
    chk8(reg_rdata, exp);
  endtask

  // Mode waits: bounded until reached, or held for a span
  task automatic waitm(input logic [3:0] m, input int lim);
    int c = 0;
    while (mode_code !== m && c < lim)
    begin
      @(negedge ref_clk);
      c++;
    end
    chkm(mode_code, m);
  endtask

  task automatic hold(input logic [3:0] m, input int cycles);
    repeat (cycles) @(negedge ref_clk);
    chkm(mode_code, m);
  endtask

  // One-cycle SLEEP; returns where the new mode is settled
  task automatic slp;
    @(posedge ref_clk);
    sleep_exec <= 1'b1;
    @(posedge ref_clk);
    sleep_exec <= 1'b0;
    @(negedge ref_clk);
  endtask

  task automatic wake(input int b, input logic [3:0] m);
    @(posedge ref_clk);
    wake_req <= WAKE_W'(1) << b;
    waitm(m, 600);
    @(posedge ref_clk);
    wake_req <= '0;
  endtask

  // Spacing of CPU ticks after two ticks to settle the divider
  task automatic spacing(input int exp);
    int c = 0;
    repeat (3)
    begin
      c = 0;
      do
      begin
        @(negedge ref_clk);
        c++;
      end
      while (cpu_tick !== 1'b1 && c < 300);
    end
    chkn(c, exp, 1);
  endtask

  // Direct transfer: way-point, then exception states on the new clock
  task automatic dt(input logic [3:0] m, input int per);
    int c = 0;
    slp;
    chkm(mode_code, PM_DT_WAY);
    while (dt_exc_start !== 1'b1 && c < 5000)
    begin
      @(negedge ref_clk);
      c++;
    end
    chkm(mode_code, PM_DT_EXC);
    c = 0;
    while (dt_done !== 1'b1 && c < 3000)
    begin
      @(negedge ref_clk);
      c++;
    end
    chkn(c, EXC_STATES * per, per);
    chkm(mode_code, m);
  endtask

  // Standby entry and wake through the settling wait
  task automatic settle(input int f);
    int c = 0;
    wr(OFS_CTRL_ONE, 8'(8'h80 | (f << 4)));
    slp;
    chkm(mode_code, PM_STANDBY);
    @(posedge ref_clk);
    wake_req <= WAKE_W'(1) << 7;
    waitm(PM_SETTLE, 8);
    while (mode_code === PM_SETTLE && c < 300)
    begin
      @(negedge ref_clk);
      c++;
    end
    chkn(c, sts_states(f) + 1, 1);
    chkm(mode_code, PM_MED);
    @(posedge ref_clk);
    wake_req <= '0;
  endtask

  // Main sequence
  initial
  begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    waitm(PM_MED, 4);
    for (i = 0; i < 5; i++)
      rd(3'(i), 8'h00);
    rd(3'h6, 8'h00);
    wr(OFS_STATUS, 8'hFF);
    rd(OFS_STATUS, 8'h02);
    repeat (4)
    begin
      rv = 8'($random(seed));
      wr(OFS_WAKE_EN0, rv);
      rd(OFS_WAKE_EN0, rv);
    end
    wr(OFS_WAKE_EN0, 8'hFF);
    wr(OFS_WAKE_EN1, 8'h9F);
    $display("end registers");
    for (i = 0; i < 4; i++)
    begin
      wr(OFS_CTRL_ONE, 8'(i));
      spacing(8 << i);
    end
    wr(OFS_CTRL_ONE, 8'h00);
    wr(OFS_CTRL_TWO, 8'h08);
    dt(PM_HIGH, 1);
    wr(OFS_CTRL_TWO, 8'h0C);
    dt(PM_MED, 8);
    $display("end direct active");
    wr(OFS_CTRL_TWO, 8'h04);
    slp;
    chkm(mode_code, PM_SLEEP);
    chk8({7'h0, cpu_halted}, 8'h01);
    @(posedge ref_clk);
    cpu_int_mask <= 1'b1;
    wake_req     <= WAKE_W'(1) << ($unsigned($random(seed)) % WAKE_W);
    hold(PM_SLEEP, 30);
    @(posedge ref_clk);
    cpu_int_mask <= 1'b0;
    waitm(PM_MED, 20);
    chk8({7'h0, cpu_halted}, 8'h00);
    @(posedge ref_clk);
    wake_req <= '0;
    for (i = 0; i < 8; i++)
      if (i != 5)
        settle(i);
    $display("end sleep and standby");
    wr(OFS_CTRL_ONE, 8'h88);
    wr(OFS_WATCH_TMR, 8'h08);
    slp;
    chkm(mode_code, PM_WATCH);
    @(posedge ref_clk);
    cpu_int_mask <= 1'b1;
    wake_req     <= WAKE_W'(1);
    hold(PM_WATCH, 30);
    wr(OFS_WAKE_EN0, 8'hFE);
    @(posedge ref_clk);
    cpu_int_mask <= 1'b0;
    hold(PM_WATCH, 10);
    wr(OFS_WAKE_EN0, 8'hFF);
    waitm(PM_SUB, 20);
    @(posedge ref_clk);
    wake_req <= '0;
    // Watch clock is 3.5 system cycles, so watch/2 is 7 cycles
    for (i = 0; i < 3; i++)
    begin
      wr(OFS_CTRL_TWO, 8'(i));
      spacing(7 << i);
    end
    wr(OFS_CTRL_TWO, 8'h00);
    wr(OFS_CTRL_ONE, 8'h08);
    slp;
    chkm(mode_code, PM_SUBSLEEP);
    wake($unsigned($random(seed)) % WAKE_W, PM_SUB);
    wr(OFS_CTRL_ONE, 8'h80);
    wr(OFS_CTRL_TWO, 8'h04);
    slp;
    chkm(mode_code, PM_WATCH);
    wake(0, PM_MED);
    wr(OFS_CTRL_ONE, 8'h88);
    wr(OFS_CTRL_TWO, 8'h0C);
    dt(PM_SUB, 7);
    wr(OFS_CTRL_ONE, 8'h80);
    wr(OFS_CTRL_TWO, 8'h08);
    dt(PM_HIGH, 1);
    wr(OFS_CTRL_ONE, 8'h88);
    wr(OFS_CTRL_TWO, 8'h0C);
    dt(PM_SUB, 7);
    wr(OFS_CTRL_ONE, 8'h80);
    dt(PM_MED, 8);
    $display("end watch and subactive");
    wr(OFS_CTRL_ONE, 8'h00);
    wr(OFS_WAKE_EN1, 8'h1F);
    wr(OFS_CTRL_TWO, 8'h08);
    slp;
    chkm(mode_code, PM_SLEEP);
    wake(7, PM_HIGH);
    wr(OFS_WAKE_EN1, 8'h9F);
    wr(OFS_CTRL_TWO, 8'h0C);
    @(posedge ref_clk);
    cpu_int_mask <= 1'b1;
    slp;
    chkm(mode_code, PM_SLEEP);
    @(posedge ref_clk);
    cpu_int_mask <= 1'b0;
    wake_req     <= WAKE_W'(1) << 7;
    hold(PM_SLEEP, 50);
    rd(OFS_STATUS, 8'h14);
    @(posedge ref_clk);
    wake_req        <= '0;
    chip_init_pin_n <= 1'b0;
    waitm(PM_RESET, 10);
    @(posedge ref_clk);
    chip_init_pin_n <= 1'b1;
    waitm(PM_MED, 10);
    rd(OFS_STATUS, 8'h02);
    $display("end lock and init pin");
    tally_and_finish;
  end

endmodule

`default_nettype wire
